// file: core/uart_baud.sv
`timescale 1ns/1ps
`default_nettype none
module uart_baud (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] rate_divisor_integer,
    input wire logic [5:0] rate_divisor_fraction,
    output logic oversample_tick
);
    logic [15:0] cnt_r;
    logic [5:0] acc_r;
    wire [6:0] acc_sum = {1'b0, acc_r} + {1'b0, rate_divisor_fraction};
    // zero integer part stops the tick rather than running at clock rate
    wire at_end = (cnt_r == 16'h0000) && (rate_divisor_integer != 16'h0000);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0000;
            acc_r <= 6'h00;
            oversample_tick <= 1'b0;
        end else begin
            oversample_tick <= at_end;
            if (at_end) begin
                acc_r <= acc_sum[5:0]; // R7
                cnt_r <= rate_divisor_integer - 16'h0001 + {15'h0000, acc_sum[6]}; // R7
            end else if (cnt_r != 16'h0000) begin
                cnt_r <= cnt_r - 16'h0001;
            end
        end
    end
    a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn) // R7
        oversample_tick && rate_divisor_integer > 16'h0001 && $stable(rate_divisor_integer) |=> !oversample_tick)
        else $error("ticks too close");
endmodule // uart_baud
`default_nettype wire

// file: core/uart_core.sv
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.svh"
// Overview of operation
// R1: transmit and receive enables set after reset
// R2: software disables module before reprogramming control
// R3: disabling finishes the current character first
// R4: send start, data lsb first, parity, stop
// R5: receive errors stored with each character
// R6: divisor is 16 integer plus 6 fraction
// R7: divisor sets bit period with fractional resolution
// R8: software rounds fraction times 64 plus half
// R9: oversample tick, divided by sixteen per bit
// R10: divisors take effect only on line write
// R11: software writes divisors, then line control
// R12: sixteen deep transmit and status receive fifos
// R13: fifo write starts frames until empty
// R14: busy until fifo empty and stop sent
// R15: start accepted only if low at eighth
// R16: data sampled every sixteen ticks after start
// R17: parity checked after data when enabled
// R18: stop not high records framing error
// R19: infrared mode modulates both line signals
// R20: infrared zero is three sixteenths pulse
// R21: low power pulse is three reference ticks
// R22: fifos single entry until deep enabled
// R23: transmit line idles high outside frames; in infrared mode the code holds it low outside frames
// R24: five to eight bits, parity, stops
// R25: low for whole frame reports break
module uart_core #(
    parameter int lp_div = `LP_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_receive_input,
    output logic serial_transmit_output
);
    function automatic logic [2:0] last_idx(input logic [1:0] wl);
        last_idx = 3'h4 + {1'b0, wl};
    endfunction

    function automatic logic [7:0] align(input logic [7:0] d, input logic [1:0] wl);
        align = d >> (2'h3 - wl);
    endfunction

    function automatic logic par_fn(input logic [7:0] d, input logic [1:0] wl, input logic ev, input logic st);
        logic [7:0] m;
        m = d & (8'hFF >> (2'h3 - wl));
        par_fn = st ? !ev : ((^m) ^ !ev);
    endfunction

    logic [9:0] ctrl_r;
    logic [15:0] idiv_r;
    logic [5:0] fdiv_r;
    logic [29:0] shadow_r;
    logic [31:0] prdata_r;
    logic rx_seen_r;
    logic oversample_tick;
    logic tx_empty, tx_full, rx_empty, rx_full;
    logic [7:0] tx_rdata;
    logic [11:0] rx_rdata;

    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_data = (paddr == `OFS_DATA);
    wire hit_flag = (paddr == `OFS_FLAG);
    wire hit_idiv = (paddr == `OFS_IDIV);
    wire hit_fdiv = (paddr == `OFS_FDIV);
    wire hit_line = (paddr == `OFS_LINE);
    wire hit_ctrl = (paddr == `OFS_CTRL);
    wire mapped = hit_data || hit_flag || hit_idiv || hit_fdiv || hit_line || hit_ctrl;
    wire wr = access && pwrite && mapped;
    wire rd = access && !pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = prdata_r;

    wire module_enable_bit = ctrl_r[`CT_ENABLE];
    wire transmit_enable_bit = ctrl_r[`CT_TXON];
    wire receive_enable_bit = ctrl_r[`CT_RXON];
    wire sir = ctrl_r[`CT_IR];
    wire sir_lp = ctrl_r[`CT_IRLP];
    wire [15:0] rate_divisor_integer = shadow_r[29:14];
    wire [5:0] rate_divisor_fraction = shadow_r[13:8];
    wire [7:0] line_ctl = shadow_r[7:0];
    wire par_on = line_ctl[`LC_PAR];
    wire par_even = line_ctl[`LC_EVEN];
    wire two_stop = line_ctl[`LC_TWOSTOP];
    wire fifo_enable_bit = line_ctl[`LC_DEEP];
    wire par_stick = line_ctl[`LC_STICK];
    wire [1:0] wl = line_ctl[`LC_WLEN +: 2]; // R24

    uart_pkg::frame_state_e tx_state_r, tx_state_nxt;
    uart_pkg::frame_state_e rx_state_r, rx_state_nxt;
    wire busy = !tx_empty || (tx_state_r != uart_pkg::st_idle); // R14
    wire [31:0] flag_w = {24'h000000, tx_empty, rx_full, tx_full, rx_empty, busy, 3'h0};
    wire [31:0] rd_mux = hit_data ? {20'h00000, rx_rdata} :
                         hit_flag ? flag_w :
                         hit_idiv ? {16'h0000, idiv_r} :
                         hit_fdiv ? {26'h0000000, fdiv_r} :
                         hit_line ? {24'h000000, line_ctl} :
                         hit_ctrl ? {22'h000000, ctrl_r} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CTRL_RST; // R1
            idiv_r <= `IDIV_RST;
            fdiv_r <= `FDIV_RST;
            shadow_r <= {`IDIV_RST, `FDIV_RST, `LINE_RST}; // R22
            prdata_r <= 32'h00000000;
            rx_seen_r <= 1'b0;
        end else begin
            if (wr && hit_ctrl) ctrl_r <= pwdata[9:0] & `CTRL_MASK;
            if (wr && hit_idiv) idiv_r <= pwdata[15:0]; // R6
            if (wr && hit_fdiv) fdiv_r <= pwdata[5:0]; // R6
            if (wr && hit_line) shadow_r <= {idiv_r, fdiv_r, pwdata[7:0]}; // R10
            if (setup) begin
                prdata_r <= rd_mux;
                rx_seen_r <= !rx_empty;
            end
        end
    end

    // a pop only when setup saw data, so a late arrival is not lost
    wire tx_push = wr && hit_data; // R13
    wire rx_pop = rd && hit_data && rx_seen_r;
    wire tx_pop;
    wire rx_push;
    wire [11:0] rx_wdata;

    uart_fifo #(.WIDTH(8), .DEPTH(16), .AW(4)) u_tx_fifo ( // R12
        .pclk(pclk),
        .presetn(presetn),
        .deep(fifo_enable_bit),
        .push(tx_push),
        .wdata(pwdata[7:0]),
        .pop(tx_pop),
        .rdata(tx_rdata),
        .empty(tx_empty),
        .full(tx_full)
    );

    uart_fifo #(.WIDTH(12), .DEPTH(16), .AW(4)) u_rx_fifo ( // R12
        .pclk(pclk),
        .presetn(presetn),
        .deep(fifo_enable_bit),
        .push(rx_push),
        .wdata(rx_wdata),
        .pop(rx_pop),
        .rdata(rx_rdata),
        .empty(rx_empty),
        .full(rx_full)
    );

    uart_baud u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .rate_divisor_integer(rate_divisor_integer),
        .rate_divisor_fraction(rate_divisor_fraction),
        .oversample_tick(oversample_tick)
    );

    logic [7:0] lp_div_r;
    logic low_power_ir_tick;
    logic [1:0] lp_w_r;
    wire lp_wrap = (lp_div_r == 8'(lp_div - 1));

    logic [3:0] tx_cnt_r;
    logic [2:0] tx_bit_r, tx_bit_nxt;
    logic [7:0] tx_shift_r, tx_shift_nxt;
    logic tx_parv_r;
    // enable gates only the start, so a running character always finishes
    wire tx_go = module_enable_bit && transmit_enable_bit && !tx_empty; // R13 R3
    assign tx_pop = (tx_state_r == uart_pkg::st_idle) && tx_go;
    wire tx_adv = oversample_tick && (tx_cnt_r == `TICK_LAST); // R9
    wire tx_line = (tx_state_r == uart_pkg::st_start) ? 1'b0 :
                   (tx_state_r == uart_pkg::st_data) ? tx_shift_r[0] :
                   (tx_state_r == uart_pkg::st_par) ? tx_parv_r : 1'b1; // R23
    wire ir_short = sir_lp ? (lp_w_r < `LP_PULSE) : (tx_cnt_r < `IR_PULSE); // R20 R21
    wire ir_out = !tx_line && ir_short; // R20

    always_comb begin
        tx_state_nxt = tx_state_r;
        tx_bit_nxt = tx_bit_r;
        tx_shift_nxt = tx_shift_r;
        case (tx_state_r)
            uart_pkg::st_idle: begin
                if (tx_pop) begin
                    tx_state_nxt = uart_pkg::st_start; // R4
                    tx_shift_nxt = tx_rdata;
                end
            end
            uart_pkg::st_start: begin
                if (tx_adv) begin
                    tx_state_nxt = uart_pkg::st_data;
                    tx_bit_nxt = 3'h0;
                end
            end
            uart_pkg::st_data: begin
                if (tx_adv) begin
                    tx_shift_nxt = {1'b1, tx_shift_r[7:1]}; // R4
                    tx_bit_nxt = tx_bit_r + 3'h1;
                    if (tx_bit_r == last_idx(wl)) begin
                        tx_bit_nxt = 3'h0;
                        tx_state_nxt = par_on ? uart_pkg::st_par : uart_pkg::st_stop; // R24
                    end
                end
            end
            uart_pkg::st_par: begin
                if (tx_adv) tx_state_nxt = uart_pkg::st_stop;
            end
            uart_pkg::st_stop: begin
                if (tx_adv && two_stop && tx_bit_r == 3'h0) begin
                    tx_bit_nxt = 3'h1; // R24
                end else if (tx_adv) begin
                    tx_state_nxt = uart_pkg::st_idle;
                end
            end
            default: tx_state_nxt = uart_pkg::st_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_r <= uart_pkg::st_idle;
            tx_cnt_r <= 4'h0;
            tx_bit_r <= 3'h0;
            tx_shift_r <= 8'h00;
            tx_parv_r <= 1'b0;
            serial_transmit_output <= 1'b1; // R23
            lp_div_r <= 8'h00;
            low_power_ir_tick <= 1'b0;
            lp_w_r <= 2'h0;
        end else begin
            tx_state_r <= tx_state_nxt;
            tx_bit_r <= tx_bit_nxt;
            tx_shift_r <= tx_shift_nxt;
            tx_cnt_r <= tx_pop ? 4'h0 : tx_cnt_r + {3'h0, oversample_tick}; // R9
            if (tx_pop) tx_parv_r <= par_fn(tx_rdata, wl, par_even, par_stick); // R24
            serial_transmit_output <= sir ? ir_out : tx_line; // R19
            lp_div_r <= lp_wrap ? 8'h00 : lp_div_r + 8'h01;
            low_power_ir_tick <= lp_wrap;
            if (tx_pop || tx_adv) begin
                lp_w_r <= 2'h0; // R21
            end else if (low_power_ir_tick && lp_w_r != `LP_PULSE) begin
                lp_w_r <= lp_w_r + 2'h1;
            end
        end
    end

    logic rx_meta_r, rx_sync_r, rx_prev_r;
    logic [4:0] ir_str_r;
    logic [3:0] rx_cnt_r, rx_cnt_nxt;
    logic [2:0] rx_idx_r, rx_idx_nxt;
    logic [7:0] rx_shift_r, rx_shift_nxt;
    logic rx_pe_r, rx_pe_nxt, rx_zero_r, rx_zero_nxt, oe_pend_r;
    // infrared pulses are stretched to one bit so the plain receiver sees levels
    wire rx_bit = sir ? (ir_str_r == 5'h00) : rx_sync_r; // R19
    wire rx_smp = oversample_tick && (rx_cnt_r == `TICK_LAST); // R16
    wire [7:0] rx_data = align(rx_shift_r, wl);
    wire rx_done = (rx_state_r == uart_pkg::st_stop) && rx_smp;
    assign rx_push = rx_done && !rx_full; // R5
    assign rx_wdata = {oe_pend_r, rx_zero_r && !rx_bit, rx_pe_r, !rx_bit, rx_data}; // R5 R18 R25

    always_comb begin
        rx_state_nxt = rx_state_r;
        rx_cnt_nxt = rx_cnt_r + {3'h0, oversample_tick};
        rx_idx_nxt = rx_idx_r;
        rx_shift_nxt = rx_shift_r;
        rx_pe_nxt = rx_pe_r;
        rx_zero_nxt = rx_zero_r;
        case (rx_state_r)
            uart_pkg::st_idle: begin
                rx_cnt_nxt = 4'h0;
                if (module_enable_bit && receive_enable_bit && rx_prev_r && !rx_bit) begin
                    rx_state_nxt = uart_pkg::st_start; // R15 R3
                end
            end
            uart_pkg::st_start: begin
                if (oversample_tick && rx_cnt_r == `TICK_MID) begin
                    rx_cnt_nxt = 4'h0;
                    rx_state_nxt = rx_bit ? uart_pkg::st_idle : uart_pkg::st_data; // R15
                    rx_idx_nxt = 3'h0;
                    rx_zero_nxt = 1'b1;
                    rx_pe_nxt = 1'b0;
                end
            end
            uart_pkg::st_data: begin
                if (rx_smp) begin
                    rx_shift_nxt = {rx_bit, rx_shift_r[7:1]}; // R16
                    rx_zero_nxt = rx_zero_r && !rx_bit; // R25
                    rx_idx_nxt = rx_idx_r + 3'h1;
                    if (rx_idx_r == last_idx(wl)) begin
                        rx_state_nxt = par_on ? uart_pkg::st_par : uart_pkg::st_stop; // R17
                    end
                end
            end
            uart_pkg::st_par: begin
                if (rx_smp) begin
                    rx_pe_nxt = rx_bit != par_fn(rx_data, wl, par_even, par_stick); // R17
                    rx_zero_nxt = rx_zero_r && !rx_bit; // R25
                    rx_state_nxt = uart_pkg::st_stop;
                end
            end
            uart_pkg::st_stop: begin
                if (rx_smp) rx_state_nxt = uart_pkg::st_idle; // R18
            end
            default: rx_state_nxt = uart_pkg::st_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_prev_r <= 1'b1;
            ir_str_r <= 5'h00;
            rx_state_r <= uart_pkg::st_idle;
            rx_cnt_r <= 4'h0;
            rx_idx_r <= 3'h0;
            rx_shift_r <= 8'h00;
            rx_pe_r <= 1'b0;
            rx_zero_r <= 1'b0;
            oe_pend_r <= 1'b0;
        end else begin
            rx_meta_r <= serial_receive_input;
            rx_sync_r <= rx_meta_r;
            rx_prev_r <= rx_bit;
            if (!rx_sync_r) begin
                ir_str_r <= `IR_STRETCH;
            end else if (oversample_tick && ir_str_r != 5'h00) begin
                ir_str_r <= ir_str_r - 5'h01;
            end
            rx_state_r <= rx_state_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_idx_r <= rx_idx_nxt;
            rx_shift_r <= rx_shift_nxt;
            rx_pe_r <= rx_pe_nxt;
            rx_zero_r <= rx_zero_nxt;
            // overrun set wins; it rides on the next stored character
            if (rx_done && rx_full) begin
                oe_pend_r <= 1'b1; // R5
            end else if (rx_push) begin
                oe_pend_r <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ctrl_reset: assert property ($rose(presetn) |-> ctrl_r[`CT_TXON] && ctrl_r[`CT_RXON]) // R1
        else $error("enables not set after reset");
    a_char_finish: assert property (tx_state_r == uart_pkg::st_data |=> tx_state_r != uart_pkg::st_idle) // R3
        else $error("character cut short");
    a_tx_order: assert property (tx_state_r == uart_pkg::st_start && tx_adv && !sir // R4
        |=> tx_state_r == uart_pkg::st_data && tx_bit_r == 3'h0 && !serial_transmit_output)
        else $error("start bit not followed by data");
    a_busy_rise: assert property (tx_push && !tx_full |=> busy[*2]) // R14
        else $error("busy missing after fifo write");
    a_shadow_hold: assert property (!(wr && hit_line) |=> $stable(shadow_r)) // R10
        else $error("divisor took effect without line write");
    a_start_reject: assert property (rx_state_r == uart_pkg::st_start && oversample_tick // R15
        && rx_cnt_r == `TICK_MID && rx_bit |=> rx_state_r == uart_pkg::st_idle && !rx_push)
        else $error("false start accepted");
    a_rx_spacing: assert property (rx_state_r == uart_pkg::st_data && !rx_smp |=> $stable(rx_shift_r)) // R16
        else $error("data sampled off the sixteenth tick");
    a_frame_err: assert property (rx_push && !rx_bit |=> !rx_empty) // R18
        else $error("framed character not stored");
    a_idle_line: assert property (tx_state_r == uart_pkg::st_idle && !sir |=> serial_transmit_output) // R23
        else $error("line not idle high");
    a_ir_pulse: assert property (sir && !sir_lp && tx_state_r == uart_pkg::st_start // R20
        && tx_cnt_r >= `IR_PULSE |=> !serial_transmit_output)
        else $error("infrared pulse too long");
endmodule // uart_core
`default_nettype wire

// file: core/uart_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module uart_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic deep,
    input wire logic push,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic pop,
    output logic [WIDTH-1:0] rdata,
    output logic empty,
    output logic full
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    wire do_push = push && !full;
    wire do_pop = pop && !empty;
    wire [AW-1:0] rd_nxt = rd_ptr_r + AW'(do_pop);
    // bypass keeps the registered head valid the cycle empty drops
    wire [WIDTH-1:0] head_nxt = (do_push && wr_ptr_r == rd_nxt) ? wdata : mem[rd_nxt];
    assign empty = (count_r == '0);
    assign full = deep ? (count_r == (AW+1)'(DEPTH)) : !empty; // R22
    always_ff @(posedge pclk) begin
        if (do_push) mem[wr_ptr_r] <= wdata;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            rdata <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + AW'(do_push);
            rd_ptr_r <= rd_nxt;
            count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
            rdata <= head_nxt;
        end
    end
    a_single_entry: assert property (@(posedge pclk) disable iff (!presetn) // R22
        !deep && count_r == 1 && !pop |=> count_r == 1) else $error("holding register took a second entry");
endmodule // uart_fifo
`default_nettype wire

// file: shared/uart_pkg.sv
`default_nettype none
package uart_pkg;
    typedef enum logic [2:0] {st_idle, st_start, st_data, st_par, st_stop} frame_state_e;
endpackage
`default_nettype wire

// file: shared/uart_regs.svh
`ifndef UART_REGS_SVH
`define UART_REGS_SVH
`define OFS_DATA 12'h000
`define OFS_FLAG 12'h004
`define OFS_IDIV 12'h008
`define OFS_FDIV 12'h00C
`define OFS_LINE 12'h010
`define OFS_CTRL 12'h014
`define CTRL_RST 10'h300
`define CTRL_MASK 10'h307
`define IDIV_RST 16'h0000
`define FDIV_RST 6'h00
`define LINE_RST 8'h00
`define CT_ENABLE 0
`define CT_IR 1
`define CT_IRLP 2
`define CT_TXON 8
`define CT_RXON 9
`define LC_PAR 1
`define LC_EVEN 2
`define LC_TWOSTOP 3
`define LC_DEEP 4
`define LC_WLEN 5
`define LC_STICK 7
`define FL_BUSY 3
`define FL_RXEMPTY 4
`define FL_TXFULL 5
`define FL_RXFULL 6
`define FL_TXEMPTY 7
`define TICK_MID 4'h7
`define TICK_LAST 4'hF
`define IR_PULSE 4'h3
`define LP_PULSE 2'h3
`define IR_STRETCH 5'h10
`define CLK_HZ 25000000
`define LP_HZ 1843200
`define LP_DIV ((`CLK_HZ + `LP_HZ / 2) / `LP_HZ)
`endif

// file: verification/async_serial_uart_core_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.svh"
module async_serial_uart_core_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_line;
    logic tx_line;
    logic [31:0] q;
    logic e;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;
    int pulses = 0;
    logic [7:0] tx_lc [5] = '{8'h76, 8'h72, 8'h86, 8'h8A, 8'h28};
    logic [7:0] tx_d [5] = '{8'h07, 8'h07, 8'h1F, 8'h13, 8'h15};
    logic [11:0] rx_f [4];
    logic [31:0] rx_exp [4] = '{32'h0A3, 32'h2A3, 32'h1A3, 32'h500};
    uart_core #(.lp_div(2)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_receive_input(rx_line), .serial_transmit_output(tx_line));
    uart_remote_model u_far (.pclk(pclk), .line_in(tx_line), .line_out(rx_line));
    always #20 pclk = ~pclk;
    // plain edges count too, so only differences are compared
    always @(posedge tx_line) pulses++;
    task automatic report_and_stop;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic er);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk); // idle edge so no signal is driven twice in one step
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask
    // expected line pattern after the start bit, idle ones padded
    function automatic logic [11:0] frame(input logic [7:0] lc, input logic [7:0] d);
        logic [11:0] f;
        int wl;
        logic p;
        wl = 5 + lc[6:5];
        f = 12'hFFF;
        for (int i = 0; i < wl; i++) f[i] = d[i];
        p = ^(d & 8'((1 << wl) - 1)) ^ !lc[`LC_EVEN];
        if (lc[`LC_STICK]) p = !lc[`LC_EVEN];
        if (lc[`LC_PAR]) f[wl] = p;
        return f;
    endfunction
    task automatic tx(input logic [7:0] lc, input logic [7:0] d, input logic put);
        n = u_far.frames;
        if (put) wr(`OFS_DATA, {24'h0, d});
        while (u_far.frames == n) @(posedge pclk);
        chk({20'h0, u_far.cap}, {20'h0, frame(lc, d)});
    endtask
    initial begin
        rx_f[0] = frame(8'h76, 8'hA3);
        rx_f[1] = rx_f[0] ^ 12'h100;
        rx_f[2] = rx_f[0] & 12'hDFF;
        rx_f[3] = 12'hC00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`OFS_CTRL, 32'h300);
        rd(`OFS_FLAG, 32'h90);
        chk({31'h0, tx_line}, 32'h1);
        apb(1'b0, 12'h018, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        wr(`OFS_DATA, 32'h55);
        rd(`OFS_FLAG, 32'h38);
        wr(`OFS_IDIV, 32'h1);
        wr(`OFS_LINE, 32'h60);
        wr(`OFS_CTRL, 32'h301);
        while (tx_line === 1'b1) @(posedge pclk);
        repeat (40) @(posedge pclk);
        wr(`OFS_CTRL, 32'h300);
        tx(8'h60, 8'h55, 1'b0);
        rd(`OFS_FLAG, 32'h90);
        // staged divisor must not change the bit period yet
        wr(`OFS_IDIV, 32'h2);
        wr(`OFS_CTRL, 32'h301);
        tx(8'h60, 8'hC4, 1'b1);
        wr(`OFS_CTRL, 32'h300);
        wr(`OFS_LINE, 32'h60);
        u_far.bit_cyc = 32;
        wr(`OFS_CTRL, 32'h301);
        tx(8'h60, 8'h3A, 1'b1);
        wr(`OFS_CTRL, 32'h300);
        wr(`OFS_IDIV, 32'h1);
        wr(`OFS_FDIV, 32'h20);
        wr(`OFS_LINE, 32'h60);
        u_far.bit_cyc = 24;
        wr(`OFS_CTRL, 32'h301);
        tx(8'h60, 8'h96, 1'b1);
        rd(`OFS_FDIV, 32'h20);
        wr(`OFS_CTRL, 32'h300);
        wr(`OFS_FDIV, 32'h0);
        u_far.bit_cyc = 16;
        for (int i = 0; i < 5; i++) begin
            wr(`OFS_LINE, {24'h0, tx_lc[i]});
            wr(`OFS_CTRL, 32'h301);
            tx(tx_lc[i], tx_d[i], 1'b1);
            wr(`OFS_CTRL, 32'h300);
        end
        wr(`OFS_LINE, 32'h76);
        wr(`OFS_CTRL, 32'h301);
        u_far.glitch();
        rd(`OFS_FLAG, 32'h90);
        for (int i = 0; i < 4; i++) begin
            u_far.send(rx_f[i]);
            rd(`OFS_DATA, rx_exp[i]);
        end
        // single-entry holding register: second character is lost
        wr(`OFS_CTRL, 32'h300);
        wr(`OFS_LINE, 32'h66);
        wr(`OFS_CTRL, 32'h301);
        u_far.send(rx_f[0]);
        u_far.send(rx_f[0]);
        rd(`OFS_DATA, 32'h0A3);
        u_far.send(rx_f[0]);
        rd(`OFS_DATA, 32'h8A3);
        wr(`OFS_CTRL, 32'h300);
        wr(`OFS_LINE, 32'h60);
        // start plus four zero data bits give five pulses
        for (int i = 0; i < 2; i++) begin
            wr(`OFS_CTRL, i ? 32'h307 : 32'h303);
            n = pulses;
            wr(`OFS_DATA, 32'h55);
            repeat (200) @(posedge pclk);
            chk(pulses - n, 32'h5);
            wr(`OFS_CTRL, 32'h300);
        end
        report_and_stop;
    end
endmodule // async_serial_uart_core_test
`default_nettype wire

// file: verification/uart_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
module uart_remote_model (
    input wire logic pclk,
    input wire logic line_in,
    output logic line_out
);
    int bit_cyc = 16;
    int frames = 0;
    logic [11:0] cap = 12'h000;
    initial line_out = 1'b1; // line pulled high when idle
    // twelve slots after start so the stop and idle levels are seen too
    initial begin
        forever begin
            @(negedge line_in);
            repeat (bit_cyc / 2) @(negedge pclk);
            if (line_in === 1'b0) begin
                for (int i = 0; i < 12; i++) begin
                    repeat (bit_cyc) @(negedge pclk);
                    cap[i] = line_in;
                end
                frames++;
            end
        end
    end
    // caller pads the tail with stop and idle ones
    task automatic send(input logic [11:0] bits);
        line_out <= 1'b0;
        repeat (16) @(posedge pclk);
        for (int i = 0; i < 12; i++) begin
            line_out <= bits[i];
            repeat (16) @(posedge pclk);
        end
    endtask
    task automatic glitch;
        line_out <= 1'b0;
        repeat (4) @(posedge pclk);
        line_out <= 1'b1;
        repeat (48) @(posedge pclk);
    endtask
endmodule // uart_remote_model
`default_nettype wire
